// file: hw/pesd_event_qualify.sv
// pesd_event_qualify: decodes the selected event and produces a per-cycle counter increment
//
// Operation
// - CBH/08H counts retired loads missing second level that start a new bus fetch.
// - load-miss events count cacheable loads only, never software prefetch loads.
// - blocked loads may go uncounted by the second-level line-miss event.
// - CBH precise samples hold next instruction address; only counter zero allowed.
// - CBH/10H counts retired translation-buffer-miss loads that did not fault.
// - CCH/01H counts first packed-integer instruction after a floating-point one.
// - CCH/02H counts first floating-point instruction after any packed-integer one.
// - CDH/00H counts assists from empty-multimedia-state changing stack state.
// - CEH/00H counts every retired packed-integer register SIMD instruction.
// - CFH counts every retired saturating-arithmetic SIMD instruction.
// - D2H/01H counts each cycle a reorder read-port stall blocks entry.
// - a persisting stall on retry next cycle is counted again.
`timescale 1ns/1ps
module pesd_event_qualify
  import pesd_pkg::*;
#(
  parameter int N_SLOTS = pesd_pkg::SLOTS,
  parameter int INC_WID = pesd_pkg::INC_W
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rstn,
  input  wire pesd_pkg::pesd_sel_t          sel,
  input  wire pesd_pkg::pesd_load_t         loads     [N_SLOTS],
  input  wire pesd_pkg::pesd_instr_t        instrs    [N_SLOTS],
  input  wire logic                         assist_stack_change,
  input  wire logic                         read_port_stall,
  output logic                [INC_WID-1:0] increment,
  output logic                              sel_illegal,
  output logic                              sample_valid,
  output logic       [pesd_pkg::ADDR_W-1:0] sample_ip
);

  function automatic logic sel_is(input pesd_sel_t s, input logic [7:0] c, input logic [7:0] m);
    sel_is = s.enable && (s.event_code == c) && (s.unit_mask == m);
  endfunction : sel_is

  function automatic logic load_ok(input pesd_load_t l);
    load_ok = l.valid && l.cacheable && !l.sw_prefetch;
  endfunction : load_ok

  // decoded selection; a disabled or unknown pair lands on EV_OFF and counts nothing
  typedef enum {
    EV_OFF,
    EV_L2_LINE,
    EV_XLATE,
    EV_TO_PI,
    EV_TO_FP,
    EV_ASSIST,
    EV_PI_RET,
    EV_SAT_RET,
    EV_RP_STALL
  } pesd_evt_t;

  function automatic pesd_evt_t decode_sel(input pesd_sel_t s);
    decode_sel = EV_OFF;
    if (sel_is(s, EVT_LOAD_RETIRED, UM_L2_LINE_MISS)) begin
      decode_sel = EV_L2_LINE;
    end else if (sel_is(s, EVT_LOAD_RETIRED, UM_XLATE_MISS)) begin
      decode_sel = EV_XLATE;
    end else if (sel_is(s, EVT_FP_PI_TRANS, UM_TO_PACKED_INT)) begin
      decode_sel = EV_TO_PI;
    end else if (sel_is(s, EVT_FP_PI_TRANS, UM_TO_FLOAT)) begin
      decode_sel = EV_TO_FP;
    end else if (sel_is(s, EVT_MM_ASSIST, UM_NONE)) begin
      decode_sel = EV_ASSIST;
    end else if (sel_is(s, EVT_PI_RETIRED, UM_NONE)) begin
      decode_sel = EV_PI_RET;
    end else if (s.enable && (s.event_code == EVT_SAT_RETIRED)) begin
      // unit mask is ignored here, so any mask selects it
      decode_sel = EV_SAT_RET;
    end else if (sel_is(s, EVT_RENAME_STALL, UM_READ_PORT_STALL)) begin
      decode_sel = EV_RP_STALL;
    end
  endfunction : decode_sel

  logic [N_SLOTS-1:0] l2_flags;
  logic [N_SLOTS-1:0] xl_flags;
  logic [N_SLOTS-1:0] pi_flags;
  logic [N_SLOTS-1:0] sat_flags;
  logic [N_SLOTS-1:0] to_pi_flags;
  logic [N_SLOTS-1:0] to_fp_flags;
  logic [N_SLOTS-1:0] slot_flags;
  logic [INC_WID-1:0] slot_cnt;

  pesd_mode_t         mode_r;
  pesd_mode_t         mode_nxt;
  logic [INC_WID-1:0] increment_nxt;
  logic               sel_illegal_nxt;
  logic               sample_valid_nxt;
  logic [ADDR_W-1:0]  sample_ip_nxt;
  logic               is_load_evt;
  pesd_evt_t          evt;

  always_comb begin
    evt         = decode_sel(sel);
    is_load_evt = (evt == EV_L2_LINE) || (evt == EV_XLATE);
  end

  // per-slot qualification; slot 0 is the oldest retiring slot
  always_comb begin
    for (int i = 0; i < N_SLOTS; i++) begin
      l2_flags[i]  = load_ok(loads[i]) && loads[i].l2_miss_bus_req && !loads[i].blocked;
      xl_flags[i]  = load_ok(loads[i]) && loads[i].xlate_miss && !loads[i].faulted;
      pi_flags[i]  = instrs[i].valid && instrs[i].is_packed_int;
      sat_flags[i] = instrs[i].valid && instrs[i].is_saturating;
    end
  end

  // transition tracking walks slots in program order so several transitions in one cycle all count
  always_comb begin
    pesd_mode_t m;
    m = mode_r;
    to_pi_flags = '0;
    to_fp_flags = '0;
    for (int i = 0; i < N_SLOTS; i++) begin
      if (instrs[i].valid && instrs[i].is_packed_int) begin
        to_pi_flags[i] = (m == ST_FLOAT);
        m = ST_PACKED_INT;
      end else if (instrs[i].valid && instrs[i].is_float) begin
        to_fp_flags[i] = (m == ST_PACKED_INT);
        m = ST_FLOAT;
      end
    end
    mode_nxt = m;
  end

  // tracker state runs whatever event is selected, so a later switch sees the true mode
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mode_r <= ST_FLOAT;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_comb begin
    case (evt)
      EV_L2_LINE: begin
        slot_flags = l2_flags;
      end
      EV_XLATE: begin
        slot_flags = xl_flags;
      end
      EV_TO_PI: begin
        slot_flags = to_pi_flags;
      end
      EV_TO_FP: begin
        slot_flags = to_fp_flags;
      end
      EV_PI_RET: begin
        slot_flags = pi_flags;
      end
      EV_SAT_RET: begin
        slot_flags = sat_flags;
      end
      EV_OFF: begin
        slot_flags = '0;
      end
      default: begin
        // assist and stall are not per slot; they bypass the slot count
        slot_flags = '0;
      end
    endcase
  end

  pesd_slot_count #(
    .N (N_SLOTS),
    .W (INC_WID)
  ) u_count (
    .flags (slot_flags),
    .count (slot_cnt)
  );

  always_comb begin
    // load events on any other counter are refused, so they never count
    sel_illegal_nxt = is_load_evt && (sel.counter_sel != COUNTER_ZERO);
    case (evt)
      EV_ASSIST: begin
        increment_nxt = INC_WID'(assist_stack_change);
      end
      EV_RP_STALL: begin
        // level per cycle, so a retried entry that stalls again counts again
        increment_nxt = INC_WID'(read_port_stall);
      end
      EV_OFF: begin
        increment_nxt = '0;
      end
      default: begin
        increment_nxt = sel_illegal_nxt ? '0 : slot_cnt;
      end
    endcase

    sample_valid_nxt = 1'b0;
    sample_ip_nxt    = sample_ip;
    // sample the oldest qualifying load; the precise address is the following instruction
    for (int i = N_SLOTS - 1; i >= 0; i--) begin
      if (is_load_evt && !sel_illegal_nxt && slot_flags[i]) begin
        sample_valid_nxt = 1'b1;
        sample_ip_nxt    = loads[i].next_ip;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      increment    <= '0;
      sel_illegal  <= 1'b0;
      sample_valid <= 1'b0;
      sample_ip    <= '0;
    end else begin
      increment    <= increment_nxt;
      sel_illegal  <= sel_illegal_nxt;
      sample_valid <= sample_valid_nxt;
      sample_ip    <= sample_ip_nxt;
    end
  end

endmodule : pesd_event_qualify

// file: hw/pesd_pkg.sv
// pesd_pkg: event codes, unit masks and carrier structs for the event qualifier
package pesd_pkg;

  localparam logic [7:0] EVT_LOAD_RETIRED   = 8'hCB;
  localparam logic [7:0] EVT_FP_PI_TRANS    = 8'hCC;
  localparam logic [7:0] EVT_MM_ASSIST      = 8'hCD;
  localparam logic [7:0] EVT_PI_RETIRED     = 8'hCE;
  localparam logic [7:0] EVT_SAT_RETIRED    = 8'hCF;
  localparam logic [7:0] EVT_RENAME_STALL   = 8'hD2;

  localparam logic [7:0] UM_L2_LINE_MISS    = 8'h08;
  localparam logic [7:0] UM_XLATE_MISS      = 8'h10;
  localparam logic [7:0] UM_TO_PACKED_INT   = 8'h01;
  localparam logic [7:0] UM_TO_FLOAT        = 8'h02;
  localparam logic [7:0] UM_NONE            = 8'h00;
  localparam logic [7:0] UM_READ_PORT_STALL = 8'h01;

  localparam logic [1:0] COUNTER_ZERO       = 2'h0;
  localparam int         SLOTS              = 4;
  localparam int         INC_W              = 3;
  localparam int         ADDR_W             = 48;

  // one retiring load per retire slot
  typedef struct packed {
    logic             valid;
    logic             cacheable;
    logic             sw_prefetch;
    logic             faulted;
    logic             blocked;
    logic             l2_miss_bus_req;
    logic             xlate_miss;
    logic [ADDR_W-1:0] next_ip;
  } pesd_load_t;

  // one retiring instruction per retire slot
  typedef struct packed {
    logic valid;
    logic is_float;
    logic is_packed_int;
    logic is_saturating;
  } pesd_instr_t;

  typedef struct packed {
    logic [7:0] event_code;
    logic [7:0] unit_mask;
    logic [1:0] counter_sel;
    logic       enable;
  } pesd_sel_t;

  typedef enum logic [0:0] { ST_FLOAT, ST_PACKED_INT } pesd_mode_t;

endpackage : pesd_pkg

// file: hw/pesd_slot_count.sv
// pesd_slot_count: population count of qualifying slot flags
`timescale 1ns/1ps
module pesd_slot_count #(
  parameter int N = 4,
  parameter int W = 3
) (
  input  wire logic [N-1:0] flags,
  output logic      [W-1:0] count
);
  always_comb begin
    count = '0;
    for (int i = 0; i < N; i++) begin
      count = count + W'(flags[i]);
    end
  end
endmodule : pesd_slot_count

// file: tb/pesd_event_qualify_sva.sv
// port-level assertions for the event qualifier
`timescale 1ns/1ps
module pesd_event_qualify_sva
  import pesd_pkg::*;
#(parameter int N_SLOTS = 4, parameter int INC_WID = 3) (
  input wire logic                  ref_clk,
  input wire logic                  rstn,
  input wire pesd_pkg::pesd_sel_t   sel,
  input wire pesd_pkg::pesd_instr_t instrs [N_SLOTS],
  input wire logic                  assist_stack_change,
  input wire logic                  read_port_stall,
  input wire logic [INC_WID-1:0]    increment,
  input wire logic                  sel_illegal,
  input wire logic                  sample_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire logic [7:0] c = sel.event_code;
  wire logic [7:0] m = sel.unit_mask;
  wire logic on = sel.enable;
  wire logic stl = on && c == EVT_RENAME_STALL && m == UM_READ_PORT_STALL && read_port_stall;
  wire logic lds = on && c == EVT_LOAD_RETIRED && sel.counter_sel == COUNTER_ZERO;
  a_stall_cycle: assert property (stl |=> increment == 1) else $error("stall cycle missed");
  a_stall_retry: assert property (stl ##1 stl |-> increment == 1 ##1 increment == 1)
    else $error("retry missed");
  a_assist_cnt: assert property (on && c == EVT_MM_ASSIST && m == UM_NONE
    |=> increment == $past(assist_stack_change)) else $error("assist count wrong");
  a_illegal_ctr: assert property (on && c == EVT_LOAD_RETIRED
    && (m == UM_L2_LINE_MISS || m == UM_XLATE_MISS) && sel.counter_sel != COUNTER_ZERO
    |=> sel_illegal && increment == 0) else $error("counter check wrong");
  a_no_enable: assert property (!on |=> increment == 0 && !sample_valid) else $error("disabled count");
  a_sat_any: assert property (on && c == EVT_SAT_RETIRED && instrs[0].valid && instrs[0].is_saturating
    |=> increment != 0) else $error("saturating missed");
  a_pi_retired: assert property (on && c == EVT_PI_RETIRED && m == UM_NONE && instrs[0].valid
    && instrs[0].is_packed_int |=> increment != 0) else $error("packed int missed");
  a_sample_src: assert property (sample_valid |-> $past(lds)) else $error("stray sample");
endmodule : pesd_event_qualify_sva
bind pesd_event_qualify pesd_event_qualify_sva #(.N_SLOTS(N_SLOTS), .INC_WID(INC_WID)) i_sva (.ref_clk(ref_clk),
  .rstn(rstn), .sel(sel), .instrs(instrs), .assist_stack_change(assist_stack_change),
  .read_port_stall(read_port_stall), .increment(increment), .sel_illegal(sel_illegal), .sample_valid(sample_valid));

// file: tb/pesd_pipe_model.sv
// pipeline model: retire slots, assist and stall lines from a stimulus word
`timescale 1ns/1ps
module pesd_pipe_model
  import pesd_pkg::*;
(
  input  wire logic [63:0]      w,
  output pesd_pkg::pesd_load_t  loads [SLOTS],
  output pesd_pkg::pesd_instr_t instrs [SLOTS],
  output logic                  assist_stack_change,
  output logic                  read_port_stall
);
  always_comb begin
    for (int i = 0; i < SLOTS; i++) begin
      // slot index in low address bits shows which slot was sampled
      loads[i] = {w[i*7 +: 7], w[63:32], 14'h0000, 2'(i)};
      // never float and packed-int in one slot, the tracker order would be moot
      instrs[i] = {w[28+i*4 +: 2], w[30+i*4] & ~w[28+i*4], w[31+i*4]};
    end
    assist_stack_change = w[44];
    read_port_stall = w[45];
  end
endmodule : pesd_pipe_model

// file: tb/tb.sv
// self-checking bench: random pipeline traffic under each event selection
`timescale 1ns/1ps
module tb;
  import pesd_pkg::*;
  logic ref_clk = 0, rstn = 0, st = 0, assist, stall, sv, ill;
  logic [63:0] w = '0;
  logic [2:0] inc;
  logic [47:0] ip, held = '0;
  logic [52:0] e, q [$];
  logic [31:0] rs = 32'h5afc_ee50;
  int failures = 0, compares = 0;
  pesd_sel_t sel = '0;
  pesd_load_t ld [SLOTS];
  pesd_instr_t ins [SLOTS];
  pesd_sel_t tbl [11] = '{{EVT_LOAD_RETIRED, UM_L2_LINE_MISS, COUNTER_ZERO, 1'b1},
    {EVT_LOAD_RETIRED, UM_XLATE_MISS, COUNTER_ZERO, 1'b1}, {EVT_FP_PI_TRANS, UM_TO_PACKED_INT, 2'h0, 1'b1},
    {EVT_FP_PI_TRANS, UM_TO_FLOAT, 2'h1, 1'b1}, {EVT_MM_ASSIST, UM_NONE, 2'h2, 1'b1},
    {EVT_PI_RETIRED, UM_NONE, 2'h3, 1'b1}, {EVT_SAT_RETIRED, 8'h5A, 2'h1, 1'b1},
    {EVT_RENAME_STALL, UM_READ_PORT_STALL, 2'h0, 1'b1}, {EVT_LOAD_RETIRED, UM_L2_LINE_MISS, 2'h3, 1'b1},
    {EVT_PI_RETIRED, 8'h01, 2'h0, 1'b1}, {EVT_LOAD_RETIRED, UM_XLATE_MISS, COUNTER_ZERO, 1'b0}};
  always #2.5 ref_clk = ~ref_clk;
  pesd_pipe_model i_pesd_pipe_model (.w(w), .loads(ld), .instrs(ins), .assist_stack_change(assist),
    .read_port_stall(stall));
  pesd_event_qualify i_pesd_event_qualify (.ref_clk(ref_clk), .rstn(rstn), .sel(sel), .loads(ld), .instrs(ins),
    .assist_stack_change(assist), .read_port_stall(stall), .increment(inc), .sel_illegal(ill),
    .sample_valid(sv), .sample_ip(ip));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // drive one cycle and note what it must produce one edge later
  task automatic step(input pesd_sel_t s_in);
    logic [2:0] n;
    logic s, lq, ldev;
    logic [47:0] a;
    @(posedge ref_clk);
    #1;
    sel = s_in;
    rs = xs(rs);
    w[31:0] = rs;
    rs = xs(rs);
    w[63:32] = rs;
    #0.1;
    {n, s} = '0;
    a = held;
    ldev = sel.enable && sel.event_code == EVT_LOAD_RETIRED
      && (sel.unit_mask == UM_L2_LINE_MISS || sel.unit_mask == UM_XLATE_MISS);
    for (int i = 0; i < SLOTS; i++) begin
      lq = ldev && sel.counter_sel == COUNTER_ZERO && ld[i].valid && ld[i].cacheable && !ld[i].sw_prefetch
        && (sel.unit_mask == UM_L2_LINE_MISS ? ld[i].l2_miss_bus_req && !ld[i].blocked
        : ld[i].xlate_miss && !ld[i].faulted);
      if (lq && !s) a = ld[i].next_ip;
      s = s | lq;
      n += lq;
      if (ins[i].valid) begin
        n += (sel.event_code == EVT_PI_RETIRED && sel.unit_mask == UM_NONE && ins[i].is_packed_int)
          + (sel.event_code == EVT_SAT_RETIRED && ins[i].is_saturating)
          + (sel.event_code == EVT_FP_PI_TRANS && sel.unit_mask == UM_TO_FLOAT && ins[i].is_float && st)
          + (sel.event_code == EVT_FP_PI_TRANS && sel.unit_mask == UM_TO_PACKED_INT && ins[i].is_packed_int && !st);
        if (ins[i].is_float) st = 0;
        else if (ins[i].is_packed_int) st = 1;
      end
    end
    n += (sel.event_code == EVT_MM_ASSIST && sel.unit_mask == UM_NONE && assist)
      + (sel.event_code == EVT_RENAME_STALL && sel.unit_mask == UM_READ_PORT_STALL && stall);
    if (!sel.enable) {n, s} = '0;
    // the sampled address holds until the next qualifying load
    if (!s) a = held;
    held = a;
    q.push_back({ldev && sel.counter_sel != COUNTER_ZERO, n, s, a});
  endtask : step
  always @(posedge ref_clk) begin
    #0.5;
    if (q.size() > 0) begin
      e = q.pop_front();
      compares++;
      if ({ill, inc, sv} !== e[52:48]) begin
        failures++;
        $display("wrong value at %0t: count %0d flags %b %b", $time, inc, ill, sv);
      end
      if (ip !== e[47:0]) begin
        failures++;
        $display("wrong value at %0t: sample address %h", $time, ip);
      end
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 rstn = 1;
    for (int t = 0; t < 11; t++) begin
      repeat (80) step(tbl[t]);
      $display("test %0d done", t);
    end
    repeat (2) @(posedge ref_clk);
    stop_test();
  end
endmodule : tb
